//--- rtl/eliec_top.sv
// external line interrupt and event controller, 24 lines, register bank on a plain port
// assumes a 25 MHz clk, synchronous srst, and a master that never overlaps strobes
//
// Functional notes
// - per-line interrupt request passes only while its interrupt mask bit is one
// - per-line event request passes only while its event mask bit is one
// - rise enable set: rising edge triggers both interrupt and event paths
// - fall enable set: falling edge triggers both interrupt and event paths
// - writing one to a clear soft trigger bit sets it and the pending flag
// - soft trigger requests still pass through the interrupt and event masks
// - clearing a pending flag by writing one also clears its soft trigger
// - enabled edge sets the pending flag only while its interrupt mask bit is one; zero means nothing since last clear
// - writing one clears a pending flag, writing zero leaves it alone
// - changing a line's edge polarity configuration clears its pending flag
// - an event is a single pulse and does not itself set pending
// - lines 0-15 from pins; 16-23 from monitor, rtc, timer, comparators
//
// Our own choice: the plain strobed port.
`default_nettype none

module eliec_top
   import eliec_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic [GPIO_LINES-1:0] gpio_line_in,
   input wire logic voltage_monitor_output,
   input wire logic rtc_alarm_in,
   input wire logic rtc_stamp_in,
   input wire logic rtc_wake_in,
   input wire logic lptim_wake_in,
   input wire logic [2:0] comp_out_in,
   output logic [LINES-1:0] line_irq,
   output logic [LINES-1:0] line_event,
   output logic irq
);

   // ----------------------------------------
   // line sources
   // ----------------------------------------
   wire [LINES-1:0] line_raw = {
      comp_out_in,
      lptim_wake_in,
      rtc_wake_in,
      rtc_stamp_in,
      rtc_alarm_in,
      voltage_monitor_output,
      gpio_line_in
   };

   eliec_link_if lk ();

   eliec_edge_detect u_edge (
      .clk (clk),
      .srst (srst),
      .line_raw (line_raw),
      .lk (lk.edge_src)
   );

   eliec_irq_status u_stat (
      .clk (clk),
      .srst (srst),
      .lk (lk.stat)
   );

   // ----------------------------------------
   // register state
   // ----------------------------------------
   eliec_line_t imask_q;
   eliec_line_t emask_q;
   eliec_line_t rise_en_q;
   eliec_line_t fall_en_q;
   eliec_line_t swtrig_q;
   eliec_line_t pend_q;
   eliec_line_t line_irq_q;
   eliec_line_t line_event_q;
   logic [DATA_W-1:0] rdata_q;

   eliec_line_t imask_d;
   eliec_line_t emask_d;
   eliec_line_t rise_en_d;
   eliec_line_t fall_en_d;
   eliec_line_t swtrig_d;
   eliec_line_t pend_d;
   eliec_line_t line_irq_d;
   eliec_line_t line_event_d;
   logic [DATA_W-1:0] rdata_d;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   wire sel_imask = reg_addr == OFS_IMASK;
   wire sel_emask = reg_addr == OFS_EMASK;
   wire sel_rise = reg_addr == OFS_RISE;
   wire sel_fall = reg_addr == OFS_FALL;
   wire sel_swtrig = reg_addr == OFS_SWTRIG;
   wire sel_pend = reg_addr == OFS_PEND;
   wire sel_stat = reg_addr == OFS_STAT;
   wire sel_smask = reg_addr == OFS_SMASK;

   wire sel_mapped = sel_imask | sel_emask | sel_rise | sel_fall
      | sel_swtrig | sel_pend | sel_stat | sel_smask;

   wire wr_imask = reg_wr & sel_imask;
   wire wr_emask = reg_wr & sel_emask;
   wire wr_rise = reg_wr & sel_rise;
   wire wr_fall = reg_wr & sel_fall;
   wire wr_swtrig = reg_wr & sel_swtrig;
   wire wr_pend = reg_wr & sel_pend;
   wire wr_smask = reg_wr & sel_smask;
   wire rd_hit_stat = reg_rd & sel_stat;

   wire [LINES-1:0] wline = reg_wdata[LINES-1:0];

   // unmapped accesses write nothing and read zero; they are flagged for software
   wire unmapped_hit = (reg_wr | reg_rd) & ~sel_mapped;

   // upper bits are ignored; a nonzero write there only raises a status flag
   wire rsvd_hit = reg_wr & sel_mapped & (|reg_wdata[DATA_W-1:LINES]);

   // ----------------------------------------
   // per-line request terms
   // ----------------------------------------
   wire [LINES-1:0] rise_trig = lk.rise & rise_en_q;
   wire [LINES-1:0] fall_trig = lk.fall & fall_en_q;
   wire [LINES-1:0] edge_trig = rise_trig | fall_trig;

   // only a 0-to-1 request of a clear bit counts as a new soft trigger
   wire [LINES-1:0] sw_new = wr_swtrig ? (wline & ~swtrig_q) : LINE_RST;

   wire [LINES-1:0] pend_w1c = wr_pend ? wline : LINE_RST;

   wire [LINES-1:0] rise_chg = wr_rise ? (wline ^ rise_en_q) : LINE_RST;
   wire [LINES-1:0] fall_chg = wr_fall ? (wline ^ fall_en_q) : LINE_RST;
   wire [LINES-1:0] polar_chg = rise_chg | fall_chg;

   // on event-only lines (interrupt mask closed) an edge gives a pulse but no pending flag
   wire [LINES-1:0] edge_pend = edge_trig & imask_q;
   wire [LINES-1:0] pend_set = edge_pend | sw_new;
   wire [LINES-1:0] pend_clr = pend_w1c | polar_chg;

   wire [LINES-1:0] evt_req = (edge_trig | sw_new) & emask_q;

   // ----------------------------------------
   // next-state, one slice per line
   // ----------------------------------------
   for (genvar i = 0; i < LINES; i++) begin : g_line
      // a new request in the clearing cycle is kept
      assign pend_d[i] = (pend_q[i] & ~pend_clr[i]) | pend_set[i];
      assign swtrig_d[i] = (swtrig_q[i] & ~pend_w1c[i]) | sw_new[i];
      assign imask_d[i] = wr_imask ? wline[i] : imask_q[i];
      assign emask_d[i] = wr_emask ? wline[i] : emask_q[i];
      assign rise_en_d[i] = wr_rise ? wline[i] : rise_en_q[i];
      assign fall_en_d[i] = wr_fall ? wline[i] : fall_en_q[i];
      assign line_irq_d[i] = pend_q[i] & imask_q[i];
      assign line_event_d[i] = evt_req[i];
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   wire [DATA_W-1:0] rd_imask = {{(DATA_W-LINES){1'b0}}, imask_q};
   wire [DATA_W-1:0] rd_emask = {{(DATA_W-LINES){1'b0}}, emask_q};
   wire [DATA_W-1:0] rd_rise = {{(DATA_W-LINES){1'b0}}, rise_en_q};
   wire [DATA_W-1:0] rd_fall = {{(DATA_W-LINES){1'b0}}, fall_en_q};
   wire [DATA_W-1:0] rd_swtrig = {{(DATA_W-LINES){1'b0}}, swtrig_q};
   wire [DATA_W-1:0] rd_pend = {{(DATA_W-LINES){1'b0}}, pend_q};
   wire [DATA_W-1:0] rd_stat = {{(DATA_W-STAT_W){1'b0}}, lk.status};
   wire [DATA_W-1:0] rd_smask = {{(DATA_W-STAT_W){1'b0}}, lk.smask};

   wire [DATA_W-1:0] rd_mux =
      sel_imask ? rd_imask :
      sel_emask ? rd_emask :
      sel_rise ? rd_rise :
      sel_fall ? rd_fall :
      sel_swtrig ? rd_swtrig :
      sel_pend ? rd_pend :
      sel_stat ? rd_stat :
      sel_smask ? rd_smask :
      RDATA_RST;

   // data stand only in the cycle after the strobe, zero otherwise
   assign rdata_d = reg_rd ? rd_mux : RDATA_RST;

   // ----------------------------------------
   // block status events
   // ----------------------------------------
   assign lk.evt[ST_PEND] = |pend_set;
   assign lk.evt[ST_EVT] = |evt_req;
   assign lk.evt[ST_UNMAP] = unmapped_hit;
   assign lk.evt[ST_RSVD] = rsvd_hit;
   assign lk.stat_rd = rd_hit_stat;
   assign lk.smask_wr = wr_smask;
   assign lk.smask_wdata = reg_wdata[STAT_W-1:0];

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         imask_q <= LINE_RST;
         emask_q <= LINE_RST;
         rise_en_q <= LINE_RST;
         fall_en_q <= LINE_RST;
      end else begin
         imask_q <= imask_d;
         emask_q <= emask_d;
         rise_en_q <= rise_en_d;
         fall_en_q <= fall_en_d;
      end
   end

   // ----------------------------------------
   // request state
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         swtrig_q <= LINE_RST;
         pend_q <= LINE_RST;
      end else begin
         swtrig_q <= swtrig_d;
         pend_q <= pend_d;
      end
   end

   // ----------------------------------------
   // output registers
   // ----------------------------------------
   // line_event and read data lag their cause by one clock, line_irq its request by two; costs latency, keeps ports glitch free
   always_ff @(posedge clk) begin
      if (srst) begin
         line_irq_q <= LINE_RST;
         line_event_q <= LINE_RST;
         rdata_q <= RDATA_RST;
      end else begin
         line_irq_q <= line_irq_d;
         line_event_q <= line_event_d;
         rdata_q <= rdata_d;
      end
   end

   assign line_irq = line_irq_q;
   assign line_event = line_event_q;
   assign reg_rdata = rdata_q;
   assign irq = lk.irq;

endmodule : eliec_top

`default_nettype wire

//--- rtl/eliec_pkg.sv
// package for the external line interrupt and event controller
// assumes a single 25 MHz bus clock and a synchronous active-high reset
`default_nettype none

package eliec_pkg;

   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int unsigned LINES = 24;
   localparam int unsigned GPIO_LINES = 16;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned STAT_W = 4;
   localparam int unsigned PRIME_W = 3;

   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] OFS_IMASK = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_EMASK = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_RISE = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_FALL = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_SWTRIG = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_PEND = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_STAT = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_SMASK = 8'h24;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [LINES-1:0] LINE_RST = 24'h00_0000;
   localparam logic [STAT_W-1:0] STAT_RST = 4'h0;
   localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;
   localparam logic [PRIME_W-1:0] PRIME_RST = 3'h0;

   // ----------------------------------------
   // block status bit positions
   // ----------------------------------------
   localparam int unsigned ST_PEND = 0;
   localparam int unsigned ST_EVT = 1;
   localparam int unsigned ST_UNMAP = 2;
   localparam int unsigned ST_RSVD = 3;

   typedef logic [LINES-1:0] eliec_line_t;

endpackage : eliec_pkg

`default_nettype wire

//--- rtl/eliec_link_if.sv
// carrier between the controller core, the edge detector and the status block
// assumes all three sit on the same clock
`default_nettype none

interface eliec_link_if;
   import eliec_pkg::*;

   eliec_line_t rise;
   eliec_line_t fall;
   eliec_line_t level;
   logic [STAT_W-1:0] evt;
   logic stat_rd;
   logic smask_wr;
   logic [STAT_W-1:0] smask_wdata;
   logic [STAT_W-1:0] status;
   logic [STAT_W-1:0] smask;
   logic irq;

   modport edge_src (output rise, output fall, output level);
   modport core (
      input rise, input fall, input level,
      output evt, output stat_rd, output smask_wr, output smask_wdata,
      input status, input smask, input irq
   );
   modport stat (
      input evt, input stat_rd, input smask_wr, input smask_wdata,
      output status, output smask, output irq
   );

endinterface : eliec_link_if

`default_nettype wire

//--- rtl/eliec_edge_detect.sv
// synchroniser and edge detector for all 24 line inputs
// assumes line inputs are asynchronous to clk
`default_nettype none

module eliec_edge_detect
   import eliec_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [LINES-1:0] line_raw,
   eliec_link_if.edge_src lk
);

   // ----------------------------------------
   // two-stage sync and history
   // ----------------------------------------
   eliec_line_t meta_q;
   eliec_line_t sync_q;
   eliec_line_t prev_q;
   logic [PRIME_W-1:0] prime_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         meta_q <= LINE_RST;
         sync_q <= LINE_RST;
         prev_q <= LINE_RST;
         prime_q <= PRIME_RST;
      end else begin
         meta_q <= line_raw;
         sync_q <= meta_q;
         prev_q <= sync_q;
         prime_q <= {prime_q[PRIME_W-2:0], 1'b1};
      end
   end

   // ----------------------------------------
   // edges
   // ----------------------------------------
   // no edges until history holds real samples, so a line high at reset is not a rise
   wire hist_ok = prime_q[PRIME_W-1];

   assign lk.level = sync_q;

   for (genvar i = 0; i < LINES; i++) begin : g_edge
      assign lk.rise[i] = hist_ok & sync_q[i] & ~prev_q[i];
      assign lk.fall[i] = hist_ok & ~sync_q[i] & prev_q[i];
   end

endmodule : eliec_edge_detect

`default_nettype wire

//--- rtl/eliec_irq_status.sv
// sticky block status, its mask and the single level interrupt
// assumes event strobes and read strobe come from logic on clk
`default_nettype none

module eliec_irq_status
   import eliec_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   eliec_link_if.stat lk
);

   logic [STAT_W-1:0] status_q;
   logic [STAT_W-1:0] smask_q;
   logic irq_q;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   // set wins over the clear-on-read, so an event in the read cycle survives
   wire [STAT_W-1:0] status_d = (status_q & ~{STAT_W{lk.stat_rd}}) | lk.evt;
   wire [STAT_W-1:0] smask_d = lk.smask_wr ? lk.smask_wdata : smask_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         status_q <= STAT_RST;
         smask_q <= STAT_RST;
         irq_q <= 1'b0;
      end else begin
         status_q <= status_d;
         smask_q <= smask_d;
         irq_q <= |(status_q & smask_q);
      end
   end

   assign lk.status = status_q;
   assign lk.smask = smask_q;
   assign lk.irq = irq_q;

endmodule : eliec_irq_status

`default_nettype wire

//--- dv/eliec_checker.sv
// port checker for the line controller, shadows the written masks
// assumes one clock domain and the plain register port
`default_nettype none

module eliec_checker
   import eliec_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic [LINES-1:0] line_irq,
   input wire logic [LINES-1:0] line_event,
   input wire logic irq
);
   // ----
   // shadows
   // ----
   eliec_line_t im_q, em_q, rt_q, ft_q, sw_q;
   logic [STAT_W-1:0] sm_q;
   wire eliec_line_t wd = reg_wdata[LINES-1:0];
   wire logic sw_wr = reg_wr && reg_addr == OFS_SWTRIG;
   // only bits that were clear count as a fresh soft trigger
   wire eliec_line_t sw_new = sw_wr ? wd & ~sw_q : LINE_RST;

   always_ff @(posedge clk) begin
      if (srst) begin
         {im_q, em_q, rt_q, ft_q, sw_q} <= {5{LINE_RST}};
         sm_q <= STAT_RST;
      end else if (reg_wr) begin
         if (reg_addr == OFS_IMASK) im_q <= wd;
         if (reg_addr == OFS_EMASK) em_q <= wd;
         if (reg_addr == OFS_RISE) rt_q <= wd;
         if (reg_addr == OFS_FALL) ft_q <= wd;
         if (reg_addr == OFS_SWTRIG) sw_q <= sw_q | wd;
         if (reg_addr == OFS_PEND) sw_q <= sw_q & ~wd;
         if (reg_addr == OFS_SMASK) sm_q <= reg_wdata[STAT_W-1:0];
      end
   end

   // ----
   // properties
   // ----
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_irq_mask;
      (line_irq & ~$past(im_q)) == LINE_RST;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("line irq on masked line");
   property p_evt_mask;
      (line_event & ~$past(em_q)) == LINE_RST;
   endproperty
   a_evt_mask: assert property (p_evt_mask) else $error("event on masked line");
   property p_evt_cause;
      (line_event & ~$past(rt_q | ft_q | sw_new)) == LINE_RST;
   endproperty
   a_evt_cause: assert property (p_evt_cause) else $error("event without cause");
   property p_evt_single;
      (line_event & $past(line_event)) == LINE_RST;
   endproperty
   a_evt_single: assert property (p_evt_single) else $error("event longer than 1");
   property p_sw_irq;
      (sw_new & im_q) != LINE_RST |-> ##2
         (line_irq & $past(sw_new & im_q, 2)) == $past(sw_new & im_q, 2);
   endproperty
   a_sw_irq: assert property (p_sw_irq) else $error("soft trigger no irq");
   property p_sw_evt;
      (sw_new & em_q) != LINE_RST |=>
         (line_event & $past(sw_new & em_q)) == $past(sw_new & em_q);
   endproperty
   a_sw_evt: assert property (p_sw_evt) else $error("soft trigger no event");
   property p_clear;
      reg_wr && reg_addr == OFS_PEND |-> ##2 (line_irq & $past(wd, 2)) == LINE_RST;
   endproperty
   a_clear: assert property (p_clear) else $error("irq after pending clear");
   property p_rd_idle;
      !$past(reg_rd) |-> reg_rdata == RDATA_RST;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   property p_irq_smask;
      irq |-> $past(sm_q) != STAT_RST;
   endproperty
   a_irq_smask: assert property (p_irq_smask) else $error("irq while status masked");

   c_sw: cover property (sw_new != LINE_RST);
   c_evt: cover property (line_event != LINE_RST);
   c_irq: cover property ($rose(irq));
endmodule : eliec_checker

bind eliec_top eliec_checker chk_u (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .line_irq, .line_event, .irq);

`default_nettype wire

//--- dv/eliec_sink.sv
// model of the event wake-up logic: counts event pulses
// assumes events arrive as one-cycle pulses on clk
`default_nettype none

module eliec_sink
   import eliec_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [LINES-1:0] line_event,
   output logic [7:0] evt_cnt_q
);
   // a stretched pulse counts twice, so the bench sees it
   always_ff @(posedge clk) begin
      if (srst) evt_cnt_q <= 8'h00;
      else evt_cnt_q <= evt_cnt_q + 8'($countones(line_event));
   end
endmodule : eliec_sink

`default_nettype wire

//--- dv/external_line_irq_event_ctrl_bench.sv
// bench for the line controller: register tasks and line stimulus
// assumes the sink model and the bound checker
`default_nettype none

module external_line_irq_event_ctrl_bench
   import eliec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [ADDR_W-1:0] reg_addr = 8'h00;
   logic [DATA_W-1:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic [LINES-1:0] ln = LINE_RST;
   logic [LINES-1:0] line_irq;
   logic [LINES-1:0] line_event;
   logic irq;
   logic [7:0] evt_cnt;
   int n_errors = 0;
   int comparisons = 0;
   int cyc = 0;

   always #20 clk = ~clk;

   eliec_top dut_u (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_line_in(ln[15:0]),
      .voltage_monitor_output(ln[16]), .rtc_alarm_in(ln[17]), .rtc_stamp_in(ln[18]),
      .rtc_wake_in(ln[19]), .lptim_wake_in(ln[20]), .comp_out_in(ln[23:21]),
      .line_irq(line_irq), .line_event(line_event), .irq(irq));
   eliec_sink sink_u (.clk(clk), .srst(srst), .line_event(line_event), .evt_cnt_q(evt_cnt));

   // ----
   // tasks
   // ----
   task automatic test_done();
      if (n_errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask : rd

   // bounded so a stuck design still reaches the verdict
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         n_errors++;
         test_done();
      end
   end

   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      // reset values; unmapped reads of 0x18 and 0x1c flag status bit 2
      for (int i = 0; i < 10; i++) rd(8'(4 * i), (i == 8) ? 32'h0000_0004 : 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         wr(8'(4 * i), 32'h00A5_5A5A);
         rd(8'(4 * i), 32'h00A5_5A5A);
         wr(8'(4 * i), 32'h0000_0000);
      end
      // every line, rising then falling
      wr(OFS_IMASK, 32'h00FF_FFFF);
      wr(OFS_EMASK, 32'h00FF_FFFF);
      for (int p = 0; p < 2; p++) begin
         wr(p ? OFS_FALL : OFS_RISE, 32'h00FF_FFFF);
         for (int i = 0; i < LINES; i++) begin
            ln[i] <= (p == 0);
            repeat (5) @(posedge clk);
            chk(line_irq, 32'h0000_0001 << i);
            rd(OFS_PEND, 32'h0000_0001 << i);
            wr(OFS_PEND, 32'h0000_0001 << i);
         end
         wr(p ? OFS_FALL : OFS_RISE, 32'h0000_0000);
      end
      chk(evt_cnt, 32'h0000_0030);
      // both masks closed
      wr(OFS_IMASK, 32'h0000_0000);
      wr(OFS_EMASK, 32'h0000_0000);
      wr(OFS_RISE, 32'h0000_0020);
      ln[5] <= 1'b1;
      repeat (5) @(posedge clk);
      rd(OFS_PEND, 32'h0000_0000);
      chk(evt_cnt, 32'h0000_0030);
      // soft trigger, then clear
      wr(OFS_RISE, 32'h0000_0000);
      wr(OFS_IMASK, 32'h0000_0080);
      wr(OFS_SWTRIG, 32'h0000_0280);
      rd(OFS_SWTRIG, 32'h0000_0280);
      rd(OFS_PEND, 32'h0000_0280);
      chk(line_irq, 32'h0000_0080);
      chk(evt_cnt, 32'h0000_0030);
      wr(OFS_SWTRIG, 32'h0000_0000);
      wr(OFS_PEND, 32'h0000_0080);
      rd(OFS_SWTRIG, 32'h0000_0200);
      rd(OFS_PEND, 32'h0000_0200);
      chk(line_irq, 32'h0000_0000);
      // same polarity keeps pending, a flip clears it
      wr(OFS_RISE, 32'h0000_0000);
      rd(OFS_PEND, 32'h0000_0200);
      wr(OFS_FALL, 32'h0000_0200);
      rd(OFS_PEND, 32'h0000_0000);
      // block status and its interrupt; unmapped flag was cleared by the first read
      rd(OFS_STAT, 32'h0000_0003);
      chk(irq, 32'h0000_0000);
      wr(OFS_SMASK, 32'h0000_0001);
      wr(OFS_SWTRIG, 32'h0000_0004);
      repeat (3) @(posedge clk);
      chk(irq, 32'h0000_0001);
      wr(OFS_PEND, 32'h0000_0004);
      rd(OFS_STAT, 32'h0000_0001);
      repeat (3) @(posedge clk);
      chk(irq, 32'h0000_0000);
      // soft trigger through an open event mask, interrupt mask closed
      wr(OFS_EMASK, 32'h0000_0008);
      wr(OFS_SWTRIG, 32'h0000_0008);
      repeat (2) @(posedge clk);
      chk(evt_cnt, 32'h0000_0031);
      chk(line_irq, 32'h0000_0000);
      rd(OFS_PEND, 32'h0000_0008);
      test_done();
   end
endmodule : external_line_irq_event_ctrl_bench

`default_nettype wire
